/* hw/battery_backed_register_bank.sv */
// Purpose: Battery-backed register bank with slow-clock source selection
// Assumes: Clock pins and rail status arrive asynchronously; requests are synchronous
// Notes: Switch outputs are select levels for a glitch-free clock mux outside
`timescale 1ns/1ps
module battery_backed_register_bank #(
   parameter int ACT_WINDOW = bbank_pkg::ACT_WINDOW_CYCLES
) (
   input wire logic clk, // Host clock
   input wire logic rst_n, // Battery-domain reset, active low
   input wire bbank_pkg::reg_req_t req, // Register request
   output logic [31:0] rdata, // Read data
   output logic rvalid, // Read data valid pulse
   input wire logic crystalPinTwo, // Crystal pin activity, async
   input wire logic externalSlowClockPin, // External 32 kHz pin, async
   input wire logic mainRail, // Main rail powered, async
   output logic crystalSingleEnded, // Crystal input type in use
   output logic alwaysOnUseCrystal, // Always-on source is crystal
   output logic domainUsePin, // Domain clock taken from external pin
   output logic domainEnable // Slow clock domain running
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   localparam int SYNC_STAGES = 3;
   localparam int N_ASYNC = 3;
   localparam int IDX_XTAL = 0;
   localparam int IDX_PIN = 1;
   localparam int IDX_RAIL = 2;
   logic [N_ASYNC-1:0] asyncIn;
   wire logic [N_ASYNC-1:0] syncEdge;
   wire logic [N_ASYNC-1:0] syncAgree;
   wire logic [N_ASYNC-1:0] syncLevel;
   logic xtalEdge, pinEdge;
   logic railOn, next_railOn;

   assign asyncIn = {mainRail, externalSlowClockPin, crystalPinTwo};

   // Three flops per pin; only the last two are read
   for (genvar g = 0; g < N_ASYNC; g++) begin : gSync
      logic [SYNC_STAGES-1:0] stages, next_stages;

      always_comb begin
         next_stages = {stages[SYNC_STAGES-2:0], asyncIn[g]};
      end

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            stages <= '0;
         end else begin
            stages <= next_stages;
         end
      end

      // Second and third stages compared
      assign syncEdge[g] = stages[SYNC_STAGES-2] ^ stages[SYNC_STAGES-1];
      assign syncAgree[g] = ~syncEdge[g];
      assign syncLevel[g] = stages[SYNC_STAGES-1];
   end

   assign xtalEdge = syncEdge[IDX_XTAL];
   assign pinEdge = syncEdge[IDX_PIN];

   // Rail level moves only once second and third stages agree
   always_comb begin
      next_railOn = railOn;
      if (syncAgree[IDX_RAIL]) begin
         next_railOn = syncLevel[IDX_RAIL];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         railOn <= 1'b0;
      end else begin
         railOn <= next_railOn;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // all state held on the battery domain
   bbank_pkg::clk_sel_t clkSel, next_clkSel;
   logic [31:0] readIncrementingCounter, next_readIncrementingCounter;
   logic [31:0] counterUpperWord, next_counterUpperWord;
   logic [3:0] wireIndexHighSave, next_wireIndexHighSave;
   logic [3:0] wireIndexLowSave, next_wireIndexLowSave;
   logic [31:0] next_rdata;
   logic next_rvalid;
   logic isRead, isWrite;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   always_comb begin
      isRead = req.valid & ~req.write;
      isWrite = req.valid & req.write;
      next_clkSel = clkSel;
      next_readIncrementingCounter = readIncrementingCounter;
      next_counterUpperWord = counterUpperWord;
      next_wireIndexHighSave = wireIndexHighSave;
      next_wireIndexLowSave = wireIndexLowSave;
      next_rdata = 32'h0;
      next_rvalid = isRead;
      // Counter, unmapped offsets and reserved bits ignore writes
      if (isWrite && hit(req.addr, bbank_pkg::OFF_CLOCK_SOURCE_SELECT)) begin
         next_clkSel = req.wdata[bbank_pkg::CLK_SEL_WIDTH-1:0];
      end
      if (isWrite && hit(req.addr, bbank_pkg::OFF_COUNTER_UPPER_WORD)) begin
         next_counterUpperWord = req.wdata;
      end
      if (isWrite && hit(req.addr, bbank_pkg::OFF_VIRTUAL_WIRE_BACKUP)) begin
         next_wireIndexHighSave = req.wdata[7:4];
         next_wireIndexLowSave = req.wdata[3:0];
      end
      if (isRead) begin
         case (req.addr)
            bbank_pkg::OFF_CLOCK_SOURCE_SELECT: begin
               next_rdata = {28'h0, clkSel};
            end
            bbank_pkg::OFF_READ_INCREMENTING_COUNTER: begin
               next_rdata = readIncrementingCounter;
               next_readIncrementingCounter = readIncrementingCounter + 32'h1;
            end
            bbank_pkg::OFF_COUNTER_UPPER_WORD: begin
               next_rdata = counterUpperWord;
            end
            bbank_pkg::OFF_VIRTUAL_WIRE_BACKUP: begin
               next_rdata = {24'h0, wireIndexHighSave, wireIndexLowSave};
            end
            default: begin
               next_rdata = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clkSel <= bbank_pkg::RESET_SEL;
         readIncrementingCounter <= bbank_pkg::RESET_WORD;
         counterUpperWord <= bbank_pkg::RESET_WORD;
         wireIndexHighSave <= bbank_pkg::RESET_SAVE[7:4];
         wireIndexLowSave <= bbank_pkg::RESET_SAVE[3:0];
         rdata <= bbank_pkg::RESET_WORD;
         rvalid <= 1'b0;
      end else begin
         clkSel <= next_clkSel;
         readIncrementingCounter <= next_readIncrementingCounter;
         counterUpperWord <= next_counterUpperWord;
         wireIndexHighSave <= next_wireIndexHighSave;
         wireIndexLowSave <= next_wireIndexLowSave;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   // ----------------------------------------
   // Activity detectors
   // ----------------------------------------
   localparam logic [bbank_pkg::ACT_CNT_W-1:0] WIN =
      bbank_pkg::ACT_CNT_W'(ACT_WINDOW);
   logic [bbank_pkg::ACT_CNT_W-1:0] xtalCnt, next_xtalCnt, pinCnt, next_pinCnt;
   logic xtalActive, next_xtalActive, pinActive, next_pinActive;
   bbank_pkg::ao_src_t aoState, next_aoState;

   always_comb begin
      next_xtalCnt = xtalCnt;
      next_xtalActive = xtalActive;
      // detection stops once crystal is in use
      if (aoState == bbank_pkg::SRC_CRYSTAL) begin
         if (!clkSel.alwaysOnSourceSelect) begin
            next_xtalCnt = '0;
            next_xtalActive = 1'b0;
         end
      end else if (xtalEdge) begin
         next_xtalCnt = '0;
         next_xtalActive = 1'b1;
      end else if (xtalCnt >= WIN) begin
         next_xtalActive = 1'b0;
      end else begin
         next_xtalCnt = xtalCnt + 1'b1;
      end
      next_pinCnt = pinCnt;
      next_pinActive = pinActive;
      if (pinEdge) begin
         next_pinCnt = '0;
         next_pinActive = 1'b1;
      end else if (pinCnt >= WIN) begin
         next_pinActive = 1'b0;
      end else begin
         next_pinCnt = pinCnt + 1'b1;
      end
   end

   // ----------------------------------------
   // Source selection
   // ----------------------------------------
   always_comb begin
      next_aoState = aoState;
      case (aoState)
         bbank_pkg::SRC_SILICON: begin
            if (clkSel.alwaysOnSourceSelect && xtalActive) begin
               next_aoState = bbank_pkg::SRC_CRYSTAL;
            end
         end
         bbank_pkg::SRC_CRYSTAL: begin
            // Clearing bit 2 returns to silicon at once
            if (!clkSel.alwaysOnSourceSelect) begin
               next_aoState = bbank_pkg::SRC_SILICON;
            end
         end
         default: begin
            next_aoState = bbank_pkg::SRC_SILICON;
         end
      endcase
   end

   // ----------------------------------------
   // Output select levels
   // ----------------------------------------
   logic next_crystalSingleEnded, next_alwaysOnUseCrystal, next_domainUsePin;
   logic next_domainEnable;

   always_comb begin
      next_crystalSingleEnded = clkSel.crystalInputType;
      next_alwaysOnUseCrystal = (aoState == bbank_pkg::SRC_CRYSTAL);
      // pin source with fallback, registered select
      next_domainUsePin = clkSel.domainPinSourceSelect & pinActive;
      next_domainEnable = next_railOn | ~clkSel.batteryOnlyDomainOff;
   end

   // detectors and source state to defaults
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xtalCnt <= '0;
         pinCnt <= '0;
         xtalActive <= 1'b0;
         pinActive <= 1'b0;
         aoState <= bbank_pkg::SRC_SILICON;
      end else begin
         xtalCnt <= next_xtalCnt;
         pinCnt <= next_pinCnt;
         xtalActive <= next_xtalActive;
         pinActive <= next_pinActive;
         aoState <= next_aoState;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crystalSingleEnded <= 1'b0;
         alwaysOnUseCrystal <= 1'b0;
         domainUsePin <= 1'b0;
         domainEnable <= 1'b1;
      end else begin
         crystalSingleEnded <= next_crystalSingleEnded;
         alwaysOnUseCrystal <= next_alwaysOnUseCrystal;
         domainUsePin <= next_domainUsePin;
         domainEnable <= next_domainEnable;
      end
   end

endmodule // battery_backed_register_bank

/* hw/bbank_pkg.sv */
// Purpose: Shared constants and types for the battery-backed register bank
// Assumes: Word-addressed internal register interface, byte offsets
// Notes: All fields reset to zero on the battery-domain reset
package bbank_pkg;
   localparam logic [7:0] OFF_CLOCK_SOURCE_SELECT = 8'h08;
   localparam logic [7:0] OFF_READ_INCREMENTING_COUNTER = 8'h20;
   localparam logic [7:0] OFF_COUNTER_UPPER_WORD = 8'h24;
   localparam logic [7:0] OFF_VIRTUAL_WIRE_BACKUP = 8'h28;

   localparam int BIT_CRYSTAL_INPUT_TYPE = 3;
   localparam int BIT_ALWAYS_ON_SOURCE_SELECT = 2;
   localparam int BIT_DOMAIN_PIN_SOURCE_SELECT = 1;
   localparam int BIT_BATTERY_ONLY_DOMAIN_OFF = 0;
   localparam int CLK_SEL_WIDTH = 4;
   localparam int WIRE_SAVE_WIDTH = 8;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [3:0] RESET_SEL = 4'h0;
   localparam logic [7:0] RESET_SAVE = 8'h00;

   // Activity window in system clocks: 32 kHz period is about 1526 clocks at 50 MHz
   localparam int CLK_HZ = 50_000_000;
   localparam int SLOW_HZ = 32_768;
   localparam int ACT_WINDOW_CYCLES = 4 * (CLK_HZ / SLOW_HZ);
   localparam int ACT_CNT_W = 13;

   typedef struct packed {
      logic crystalInputType;
      logic alwaysOnSourceSelect;
      logic domainPinSourceSelect;
      logic batteryOnlyDomainOff;
   } clk_sel_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {
      SRC_SILICON = 2'b00,
      SRC_CRYSTAL = 2'b01
   } ao_src_t;
endpackage

/* testbench/bank_checker_sva.sv */
// Purpose: Port checks for the battery-backed register bank
// Assumes: One host clock, async active-low battery reset
// Notes: Quiet counters measure idle time on the slow clock pins
`timescale 1ns/1ps
module bank_checker #(
   parameter int ACT_WINDOW = 20
) (
   input wire logic clk, // Host clock
   input wire logic rst_n, // Battery reset
   input wire bbank_pkg::reg_req_t req, // Request
   input wire logic [31:0] rdata, // Read data
   input wire logic rvalid, // Read valid
   input wire logic crystalPinTwo, // Crystal pin
   input wire logic externalSlowClockPin, // External pin
   input wire logic mainRail, // Rail level
   input wire logic crystalSingleEnded, // Input type
   input wire logic alwaysOnUseCrystal, // Crystal in use
   input wire logic domainUsePin, // Pin in use
   input wire logic domainEnable // Domain running
);
   int xQuiet, pQuiet;
   logic xPrev, pPrev, rd;
   assign rd = req.valid && !req.write;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {xPrev, pPrev, xQuiet, pQuiet} <= '0;
      end else begin
         xPrev <= crystalPinTwo;
         pPrev <= externalSlowClockPin;
         xQuiet <= (crystalPinTwo != xPrev) ? 0 : xQuiet + (xQuiet < 999);
         pQuiet <= (externalSlowClockPin != pPrev) ? 0 : pQuiet + (pQuiet < 999);
      end
   end
   read_answer_a: assert property (rd |=> rvalid)
      else $error("read got no answer");
   idle_zero_a: assert property (!rvalid |-> rdata == 32'h0)
      else $error("read data not zero when idle");
   count_step_a: assert property ((rd && req.addr == 8'h20) ##1 (rd && req.addr == 8'h20) |=> rdata == $past(rdata) + 32'h1)
      else $error("counter did not step by one");
   sel_reserved_a: assert property (rd && req.addr == 8'h08 |=> rdata[31:4] == 28'h0)
      else $error("reserved select bits not zero");
   type_follow_a: assert property (req.valid && req.write && req.addr == 8'h08 |-> ##2 crystalSingleEnded == $past(req.wdata[3], 2))
      else $error("input type not following bit 3");
   rail_domain_a: assert property (mainRail [*6] |-> domainEnable)
      else $error("domain off while rail on");
   pin_fallback_a: assert property (pQuiet > ACT_WINDOW + 10 |-> !domainUsePin)
      else $error("no fallback from idle pin");
   pin_rise_a: assert property ($rose(domainUsePin) |-> pQuiet < ACT_WINDOW + 10)
      else $error("pin selected without activity");
   xtal_rise_a: assert property ($rose(alwaysOnUseCrystal) |-> xQuiet < ACT_WINDOW + 10)
      else $error("crystal selected without activity");
   cover property (rvalid && rdata != 32'h0);
   cover property ($rose(alwaysOnUseCrystal));
   cover property ($fell(domainUsePin));
endmodule // bank_checker

/* testbench/testbench.sv */
// Purpose: Register and slow clock selection tests for the bank
// Assumes: Activity window shortened to 20 clocks
// Notes: Pins toggle each clock while their run flag is set
`timescale 1ns/1ps
bind battery_backed_register_bank bank_checker #(.ACT_WINDOW(ACT_WINDOW)) uSva (.clk, .rst_n,
   .req, .rdata, .rvalid, .crystalPinTwo, .externalSlowClockPin, .mainRail,
   .crystalSingleEnded, .alwaysOnUseCrystal, .domainUsePin, .domainEnable);
module testbench;
   logic clk = 0, rst_n = 0, xtal = 0, ext = 0, rail = 0, xRun = 0, pRun = 0;
   logic rvalid, single, aoX, useP, domEn;
   logic [31:0] rdata;
   bbank_pkg::reg_req_t req = '0;
   int errors = 0, n_compared = 0, k;
   localparam int W_SINGLE = 0, W_AOX = 1, W_USEP = 2, W_DOMEN = 3;
   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (xRun) xtal <= ~xtal;
      if (pRun) ext <= ~ext;
   end
   battery_backed_register_bank #(.ACT_WINDOW(20)) DUT (.clk(clk), .rst_n(rst_n), .req(req),
      .rdata(rdata), .rvalid(rvalid), .crystalPinTwo(xtal), .externalSlowClockPin(ext),
      .mainRail(rail), .crystalSingleEnded(single), .alwaysOnUseCrystal(aoX),
      .domainUsePin(useP), .domainEnable(domEn));
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic put(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) req <= '{1'b1, w, a, d};
      @(posedge clk) req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      put(1'b0, a, 32'h0);
      #1 check({rvalid, rdata}, {1'b1, exp});
   endtask
   // Output picked at compare time, not at call time
   function automatic logic pick(input int w);
      case (w)
         W_SINGLE: pick = single;
         W_AOX: pick = aoX;
         W_USEP: pick = useP;
         default: pick = domEn;
      endcase
   endfunction
   task automatic settle(input int w, input logic v);
      logic s;
      for (k = 0; k < 60; k++) begin
         @(posedge clk) #1 s = pick(w);
         if (s === v) break;
      end
      check({32'h0, s}, {32'h0, v});
      if (s !== v) give_verdict();
   endtask
   task automatic hold(input int n, input int w, input logic v);
      repeat (n) @(posedge clk);
      #1 check({32'h0, pick(w)}, {32'h0, v});
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h08, 32'h0);
      rd(8'h24, 32'h0);
      rd(8'h28, 32'h0);
      rd(8'h20, 32'h0);
      rd(8'h20, 32'h1);
      put(1'b1, 8'h20, 32'h55);
      rd(8'h20, 32'h2);
      @(posedge clk) req <= '{1'b1, 1'b0, 8'h20, 32'h0};
      @(posedge clk) #1 check({rvalid, rdata}, {1'b1, 32'h3});
      @(posedge clk) req <= '0;
      #1 check({rvalid, rdata}, {1'b1, 32'h4});
      put(1'b1, 8'h24, 32'h89ab_cdef);
      rd(8'h24, 32'h89ab_cdef);
      put(1'b1, 8'h28, 32'hffff_ffff);
      rd(8'h28, 32'h0000_00ff);
      put(1'b1, 8'h28, 32'h0000_00a5);
      rd(8'h28, 32'h0000_00a5);
      put(1'b1, 8'h10, 32'hffff_ffff);
      rd(8'h10, 32'h0);
      $display("test registers done");
      put(1'b1, 8'h08, 32'hffff_fffc);
      rd(8'h08, 32'h0000_000c);
      hold(1, W_SINGLE, 1'b1);
      hold(40, W_AOX, 1'b0);
      xRun <= 1'b1;
      settle(W_AOX, 1'b1);
      put(1'b1, 8'h08, 32'h0000_0002);
      settle(W_AOX, 1'b0);
      hold(40, W_USEP, 1'b0);
      pRun <= 1'b1;
      settle(W_USEP, 1'b1);
      pRun <= 1'b0;
      settle(W_USEP, 1'b0);
      $display("test sources done");
      put(1'b1, 8'h08, 32'h0000_0001);
      hold(8, W_DOMEN, 1'b0);
      @(posedge clk) rail <= 1'b1;
      hold(8, W_DOMEN, 1'b1);
      @(posedge clk) rail <= 1'b0;
      put(1'b1, 8'h08, 32'h0000_0000);
      hold(8, W_DOMEN, 1'b1);
      $display("test domain done");
      put(1'b1, 8'h08, 32'h0000_0005);
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h20, 32'h0);
      rd(8'h08, 32'h0);
      rd(8'h24, 32'h0);
      rd(8'h28, 32'h0);
      $display("test second reset done");
      give_verdict();
   end
endmodule // testbench
